/* include/dbc_pkg.sv */
// Shared constants and types for the breakpoint and debug controller block
package dbc_pkg;

    // Register widths
    localparam int STATUS_W = 8;
    localparam int ADDR_W = 16;

    // Bit positions inside debug_status_control
    localparam int BIT_ENBL = 7;    // background_mode_enable
    localparam int BIT_ACT = 6;     // background_active_flag
    localparam int BIT_BKEN = 5;    // match address breakpoint enable
    localparam int BIT_FRC = 4;     // match address breakpoint is force type
    localparam int BIT_CLKS = 3;    // debug_clock_select
    localparam int BIT_WAIT = 2;      // wait_or_stop_flag
    localparam int BIT_WAIT_FAIL = 1; // wait_or_stop_failure_flag
    localparam int BIT_DATA_FAIL = 0; // data_valid_failure_flag

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] MATCH_RST = 16'h0000;

    // Depth of the instruction queue that carries tag marks
    localparam int QUEUE_DEPTH = 4;

    // Decoded serial debug commands, delivered by the serial engine
    typedef enum logic [2:0] {
        DBC_CMD_RD_STATUS,
        DBC_CMD_WR_CONTROL,
        DBC_CMD_RD_MATCH,
        DBC_CMD_WR_MATCH,
        DBC_CMD_GO,
        DBC_CMD_HALT
    } dbc_cmd_t;

    // One command from the serial engine
    typedef struct packed {
        logic valid;            // Command strobe, one cycle
        dbc_cmd_t op;           // Which command
        logic [15:0] data;      // Write data, low byte for control
    } dbc_cmd_req_t;

    // Read answer back to the serial engine
    typedef struct packed {
        logic valid;            // Answer strobe, one cycle
        logic [15:0] data;      // Read data, status in low byte
    } dbc_cmd_rsp_t;

    // Opcode fetch entering the instruction queue
    typedef struct packed {
        logic push;             // Opcode enters queue this cycle
        logic [15:0] addr;      // Address it was fetched from
    } dbc_fetch_t;

    // Read-only status inputs from the core
    typedef struct packed {
        logic wait_stop;        // Core is in wait or stop
        logic wait_stop_fail;   // Wait or stop failed to complete
        logic data_valid_fail;  // Data valid failure seen
    } dbc_core_stat_t;

    // Force request sequencing
    typedef enum logic [0:0] {
        DBC_FRC_IDLE,
        DBC_FRC_WAIT
    } dbc_frc_state_t;

endpackage

/* hw/dbc_tag_queue.sv */
`timescale 1ns/1ps
// Shadow of the instruction queue holding one tag mark per opcode
module dbc_tag_queue #(
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic push_i,
    input wire logic push_tag_i,
    input wire logic pop_i,
    input wire logic flush_i,
    output logic head_tag_o,
    output logic empty_o
);
    localparam int PW = $clog2(DEPTH);

    logic [DEPTH-1:0] tag_r;        // One mark per queue slot
    logic [PW-1:0] wr_ptr_r;        // Next free slot
    logic [PW-1:0] rd_ptr_r;        // Oldest opcode
    logic [PW:0] count_r;           // Opcodes held

    // Head mark; a pop on an empty queue reads as unmarked
    assign empty_o = (count_r == '0);
    assign head_tag_o = empty_o ? 1'b0 : tag_r[rd_ptr_r];

    // Pointer upkeep; a flush throws away every held opcode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (flush_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            // Core never overfills its own queue
            if (push_i) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop_i && !empty_o) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (PW+1)'(push_i)
                - (PW+1)'(pop_i && !empty_o);
        end
    end

    // Mark storage, written with the opcode it belongs to
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tag_r <= '0;
        end else if (push_i && !flush_i) begin
            tag_r[wr_ptr_r] <= push_tag_i;
        end
    end

endmodule

/* hw/dbc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Enable bit gates triggers into breakpoint requests
// - Tag select picks tag or force request
// - Tag marks opcode entering the instruction queue
// - Executed marked opcode halts; discarded one never does
// - Force finishes current instruction, then halts
// - Without background enable, breakpoint takes software interrupt
// - Registers reachable only by serial debug commands
// - Eight-bit status register, sixteen-bit match address
// - Background enable write refused while background active
// - Four status bits are read-only
// - Clock select and registers accessible at any time
module dbc_top #(
    parameter int QDEPTH = dbc_pkg::QUEUE_DEPTH
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    // Loose bits of the debug control register
    input wire logic breakpoint_request_enable_i,
    input wire logic tag_select_i,
    // Qualified trigger from the comparator logic
    input wire logic trigger_i,
    // Core pipeline view
    input wire dbc_pkg::dbc_fetch_t fetch_i,
    input wire logic exec_start_i,
    input wire logic queue_flush_i,
    input wire logic instr_done_i,
    input wire dbc_pkg::dbc_core_stat_t core_stat_i,
    // Decoded commands from the single-wire serial engine
    input wire dbc_pkg::dbc_cmd_req_t cmd_i,
    output dbc_pkg::dbc_cmd_rsp_t rsp_o,
    // Actions toward the core
    output logic enter_background_o,
    output logic take_soft_int_o,
    output logic background_active_o,
    output logic debug_clock_select_o
);

    // Reset release synchroniser
    logic [1:0] rst_sync_r;
    logic rst_n;

    // Bits of debug_status_control held here, and the match address
    logic enbl_r;           // background_mode_enable
    logic bken_r;           // Match address breakpoint enable
    logic frc_r;            // Match address breakpoint is force type
    logic clks_r;           // debug_clock_select
    logic active_r;         // background_active_flag
    logic [15:0] match_r;   // debug_breakpoint_match_address

    // Answer registers
    logic rsp_valid_r;
    logic [15:0] rsp_data_r;

    // Breakpoint request path
    logic trig_req;         // Gated trigger
    logic match_hit;        // Fetch address equals match register
    logic tag_req;          // Any tag-type request this cycle
    logic force_req;        // Any force-type request this cycle
    logic tag_pend_r;       // Tag request waiting for an opcode
    logic push_tag;         // Mark for the opcode now entering
    logic head_tag;         // Mark of the opcode now executing
    logic q_empty;
    logic tag_fire;         // Marked opcode reached end of pipe

    // Force sequencing
    dbc_pkg::dbc_frc_state_t frc_state_r;
    dbc_pkg::dbc_frc_state_t frc_state_nxt;
    logic force_fire;       // Current instruction done, act now

    // Host halt request
    logic host_halt;
    logic host_go;

    // Actions, registered so the core sees clean pulses
    logic enter_bg_r;
    logic soft_int_r;
    logic enter_bg_nxt;
    logic soft_int_nxt;

    // Assembled status byte
    logic [7:0] status_byte;

    // Reset: asynchronous assert, release after two edges
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Status byte as the host reads it
    always_comb begin
        status_byte = dbc_pkg::STATUS_RST;
        status_byte[dbc_pkg::BIT_ENBL] = enbl_r;
        status_byte[dbc_pkg::BIT_ACT] = active_r;
        status_byte[dbc_pkg::BIT_BKEN] = bken_r;
        status_byte[dbc_pkg::BIT_FRC] = frc_r;
        status_byte[dbc_pkg::BIT_CLKS] = clks_r;
        // Core status flags pass straight through, never stored
        status_byte[dbc_pkg::BIT_WAIT] = core_stat_i.wait_stop;
        status_byte[dbc_pkg::BIT_WAIT_FAIL] = core_stat_i.wait_stop_fail;
        status_byte[dbc_pkg::BIT_DATA_FAIL] = core_stat_i.data_valid_fail;
    end

    // Command decode; no memory-mapped path exists into these registers
    assign host_halt = cmd_i.valid
        && (cmd_i.op == dbc_pkg::DBC_CMD_HALT) && enbl_r;
    // Resume is honoured whatever the enable bit holds
    assign host_go = cmd_i.valid && (cmd_i.op == dbc_pkg::DBC_CMD_GO);

    // Control writes; status flags are not stored here at all
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            enbl_r <= dbc_pkg::STATUS_RST[dbc_pkg::BIT_ENBL];
            bken_r <= dbc_pkg::STATUS_RST[dbc_pkg::BIT_BKEN];
            frc_r <= dbc_pkg::STATUS_RST[dbc_pkg::BIT_FRC];
            clks_r <= dbc_pkg::STATUS_RST[dbc_pkg::BIT_CLKS];
        end else if (cmd_i.valid
                && cmd_i.op == dbc_pkg::DBC_CMD_WR_CONTROL) begin
            // Clock select accepted in any mode
            clks_r <= cmd_i.data[dbc_pkg::BIT_CLKS];
            bken_r <= cmd_i.data[dbc_pkg::BIT_BKEN];
            frc_r <= cmd_i.data[dbc_pkg::BIT_FRC];
            // Enable may not forbid a mode already entered
            if (!active_r) begin
                enbl_r <= cmd_i.data[dbc_pkg::BIT_ENBL];
            end
            // Read-only status bits of the write are dropped
        end
    end

    // Match address register, writable at any time
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            match_r <= dbc_pkg::MATCH_RST;
        end else if (cmd_i.valid
                && cmd_i.op == dbc_pkg::DBC_CMD_WR_MATCH) begin
            match_r <= cmd_i.data;
        end
    end

    // Read answers, one cycle after the command
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 16'h0000;
        end else begin
            rsp_valid_r <= 1'b0;
            if (cmd_i.valid) begin
                unique case (cmd_i.op)
                    dbc_pkg::DBC_CMD_RD_STATUS: begin
                        // Eight bits, upper byte reads as zero
                        rsp_valid_r <= 1'b1;
                        rsp_data_r <= {8'h00, status_byte};
                    end
                    dbc_pkg::DBC_CMD_RD_MATCH: begin
                        rsp_valid_r <= 1'b1;
                        rsp_data_r <= match_r;
                    end
                    default: begin
                        // Writes and run control give no answer
                        rsp_valid_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Trigger gating; nothing is raised while the core is halted
    assign trig_req = breakpoint_request_enable_i && trigger_i
        && !active_r;
    // Match register breakpoint on opcode fetch address
    assign match_hit = bken_r && fetch_i.push && !active_r
        && (fetch_i.addr == match_r);
    // Split each source into tag or force
    assign tag_req = (trig_req && tag_select_i)
        || (match_hit && !frc_r);
    assign force_req = (trig_req && !tag_select_i)
        || (match_hit && frc_r);

    // Request without a fetch waits for the next opcode to enter
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tag_pend_r <= 1'b0;
        end else if (queue_flush_i || active_r) begin
            tag_pend_r <= 1'b0;
        // Mark handed to the opcode entering now
        end else if (fetch_i.push) begin
            tag_pend_r <= 1'b0;
        end else if (tag_req) begin
            tag_pend_r <= 1'b1;
        end
    end

    // Mark travels with the opcode entering the queue now
    assign push_tag = fetch_i.push && (tag_req || tag_pend_r);

    // Mark shadow; a flush loses marks together with their opcodes
    dbc_tag_queue #(
        .DEPTH(QDEPTH)
    ) u_tag_queue (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .push_i(fetch_i.push),
        .push_tag_i(push_tag),
        .pop_i(exec_start_i),
        .flush_i(queue_flush_i),
        .head_tag_o(head_tag),
        .empty_o(q_empty)
    );

    // Only an opcode that really executes halts; flushed marks vanish
    assign tag_fire = exec_start_i && head_tag && !q_empty
        && !active_r;

    // Force sequencing: hold the request until the instruction ends
    always_comb begin
        frc_state_nxt = frc_state_r;
        force_fire = 1'b0;
        unique case (frc_state_r)
            dbc_pkg::DBC_FRC_IDLE: begin
                if (force_req && instr_done_i) begin
                    // Request lands as the current instruction ends
                    force_fire = 1'b1;
                end else if (force_req) begin
                    frc_state_nxt = dbc_pkg::DBC_FRC_WAIT;
                end
            end
            dbc_pkg::DBC_FRC_WAIT: begin
                if (active_r) begin
                    // Halted by another path, request is spent
                    frc_state_nxt = dbc_pkg::DBC_FRC_IDLE;
                end else if (instr_done_i) begin
                    force_fire = 1'b1;
                    frc_state_nxt = dbc_pkg::DBC_FRC_IDLE;
                end
            end
        endcase
    end

    // Force state register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            frc_state_r <= dbc_pkg::DBC_FRC_IDLE;
        end else begin
            frc_state_r <= frc_state_nxt;
        end
    end

    // Choose halt or software interrupt from the enable bit
    always_comb begin
        enter_bg_nxt = 1'b0;
        soft_int_nxt = 1'b0;
        if (tag_fire || force_fire) begin
            // Enable bit is taken as it stands at the firing edge
            if (enbl_r) begin
                enter_bg_nxt = 1'b1;
            end else begin
                soft_int_nxt = 1'b1;
            end
        end else if (host_halt && !active_r) begin
            // Host halt only when background mode is allowed
            enter_bg_nxt = 1'b1;
        end
    end

    // Action pulses toward the core
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            enter_bg_r <= 1'b0;
            soft_int_r <= 1'b0;
        end else begin
            enter_bg_r <= enter_bg_nxt;
            soft_int_r <= soft_int_nxt;
        end
    end

    // Active flag: entry wins over a go in the same cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= dbc_pkg::STATUS_RST[dbc_pkg::BIT_ACT];
        end else if (enter_bg_nxt) begin
            active_r <= 1'b1;
        // Resume drops the flag one edge after the command
        end else if (host_go) begin
            active_r <= 1'b0;
        end
    end

    // Outputs
    assign rsp_o.valid = rsp_valid_r;
    assign rsp_o.data = rsp_data_r;
    assign enter_background_o = enter_bg_r;
    assign take_soft_int_o = soft_int_r;
    assign background_active_o = active_r;
    assign debug_clock_select_o = clks_r;

endmodule

/* dv/dbc_top_assertions.sv */
`timescale 1ns/1ps
// Port-level checks on the breakpoint and debug controller block
module dbc_top_assertions #(
    parameter int QDEPTH = 4
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic breakpoint_request_enable_i,
    input wire logic tag_select_i,
    input wire logic trigger_i,
    input wire dbc_pkg::dbc_fetch_t fetch_i,
    input wire logic exec_start_i,
    input wire logic queue_flush_i,
    input wire logic instr_done_i,
    input wire dbc_pkg::dbc_core_stat_t core_stat_i,
    input wire dbc_pkg::dbc_cmd_req_t cmd_i,
    input wire dbc_pkg::dbc_cmd_rsp_t rsp_o,
    input wire logic enter_background_o,
    input wire logic take_soft_int_o,
    input wire logic background_active_o,
    input wire logic debug_clock_select_o
);
    // Command decode helpers, taken on the sampling edge
    wire logic is_rd = cmd_i.valid
        && (cmd_i.op == dbc_pkg::DBC_CMD_RD_STATUS
        || cmd_i.op == dbc_pkg::DBC_CMD_RD_MATCH);
    wire logic is_wr_ctl = cmd_i.valid
        && cmd_i.op == dbc_pkg::DBC_CMD_WR_CONTROL;
    wire logic is_go = cmd_i.valid && cmd_i.op == dbc_pkg::DBC_CMD_GO;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Status read taken this edge
    sequence status_rd_s;
        cmd_i.valid && cmd_i.op == dbc_pkg::DBC_CMD_RD_STATUS;
    endsequence
    // Force request meeting a completing instruction
    sequence force_hit_s;
        trigger_i && breakpoint_request_enable_i && !tag_select_i
            && !background_active_o && instr_done_i;
    endsequence

    act_rise_a: assert property (
        $rose(background_active_o) |-> enter_background_o)
        else $error("active flag rose without entry pulse");
    enter_pulse_a: assert property (
        enter_background_o && !is_go
            |=> !enter_background_o && background_active_o)
        else $error("entry pulse too long or active flag dropped");
    softint_idle_a: assert property (
        take_soft_int_o |-> !background_active_o && !enter_background_o)
        else $error("interrupt taken together with background entry");
    force_done_a: assert property (
        force_hit_s |=> enter_background_o || take_soft_int_o)
        else $error("force request not acted on after done");
    status_read_a: assert property (
        status_rd_s |=> rsp_o.valid && rsp_o.data[15:8] == 8'h00
            && rsp_o.data[2:0] == $past(core_stat_i)
            && rsp_o.data[6] == $past(background_active_o))
        else $error("status read answer wrong");
    rd_answer_a: assert property (
        is_rd |=> rsp_o.valid)
        else $error("read command got no answer");
    rsp_only_a: assert property (
        rsp_o.valid |-> $past(is_rd))
        else $error("answer strobe without read command");
    clksel_wr_a: assert property (
        is_wr_ctl |=> debug_clock_select_o
            == $past(cmd_i.data[dbc_pkg::BIT_CLKS]))
        else $error("clock select not taken from control write");
    act_keep_a: assert property (
        background_active_o && !is_go |=> background_active_o)
        else $error("active flag changed without resume command");
endmodule

bind dbc_top dbc_top_assertions #(.QDEPTH(QDEPTH)) chk_u (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .breakpoint_request_enable_i(breakpoint_request_enable_i),
    .tag_select_i(tag_select_i), .trigger_i(trigger_i),
    .fetch_i(fetch_i), .exec_start_i(exec_start_i),
    .queue_flush_i(queue_flush_i), .instr_done_i(instr_done_i),
    .core_stat_i(core_stat_i), .cmd_i(cmd_i), .rsp_o(rsp_o),
    .enter_background_o(enter_background_o),
    .take_soft_int_o(take_soft_int_o),
    .background_active_o(background_active_o),
    .debug_clock_select_o(debug_clock_select_o)
);

/* dv/dbc_host_model.sv */
`timescale 1ns/1ps
// Debug host: issues decoded serial commands one at a time
module dbc_host_model (
    input wire logic clk_i,
    input wire dbc_pkg::dbc_cmd_rsp_t rsp_i,
    output dbc_pkg::dbc_cmd_req_t cmd_o
);
    // Quiet command port at start
    initial begin
        cmd_o = '0;
    end
    // One command; gap models a slow host, reads wait a bounded time
    task automatic xfer(input dbc_pkg::dbc_cmd_t op,
            input logic [15:0] wdata, input int gap,
            output logic [15:0] rdata);
        int n;
        rdata = 'x;
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        cmd_o <= '{valid: 1'b1, op: op, data: wdata};
        @(posedge clk_i);
        cmd_o.valid <= 1'b0;
        cmd_o.data <= ~wdata; // Idle data must not echo the last value
        if (op == dbc_pkg::DBC_CMD_RD_STATUS
                || op == dbc_pkg::DBC_CMD_RD_MATCH) begin
            for (n = 0; n < 4; n++) begin
                @(posedge clk_i);
                if (rsp_i.valid === 1'b1) begin
                    rdata = rsp_i.data;
                    break;
                end
            end
        end
    endtask
endmodule

/* dv/test_debug_breakpoint_control.sv */
`timescale 1ns/1ps
// Directed bench: host commands plus core pipeline pulses
module test_debug_breakpoint_bdc_control;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic brk_en = 1'b0; // Loose enable bit
    logic tag_sel = 1'b0; // Loose tag select bit
    logic trig = 1'b0;
    logic exec_start = 1'b0;
    logic flush = 1'b0;
    logic done = 1'b0;
    dbc_pkg::dbc_fetch_t fetch = '{push: 1'b0, addr: 16'h1000};
    dbc_pkg::dbc_core_stat_t stat = 3'h5; // Wait flag and data flag
    dbc_pkg::dbc_cmd_req_t cmd;
    dbc_pkg::dbc_cmd_rsp_t rsp;
    logic enter, soft_int, act, clksel;
    logic [15:0] rd;
    int failures = 0;
    int checked = 0;
    int n_enter = 0; // Entry pulses seen
    int n_soft_int = 0; // Interrupt pulses seen

    always #5 clk_i = ~clk_i;

    dbc_top dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i),
        .breakpoint_request_enable_i(brk_en), .tag_select_i(tag_sel),
        .trigger_i(trig), .fetch_i(fetch), .exec_start_i(exec_start),
        .queue_flush_i(flush), .instr_done_i(done), .core_stat_i(stat),
        .cmd_i(cmd), .rsp_o(rsp), .enter_background_o(enter),
        .take_soft_int_o(soft_int), .background_active_o(act),
        .debug_clock_select_o(clksel)
    );
    dbc_host_model host_u (.clk_i(clk_i), .rsp_i(rsp), .cmd_o(cmd));

    // Count action pulses so bursts or misses both show
    always @(posedge clk_i) begin
        if (enter === 1'b1) n_enter++;
        if (soft_int === 1'b1) n_soft_int++;
    end

    task automatic chk(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One cycle of core pulses: push, trigger, exec, flush, done
    task automatic cyc(input logic [4:0] v);
        @(posedge clk_i);
        {fetch.push, trig, exec_start, flush, done} <= v;
    endtask
    task automatic wr(input dbc_pkg::dbc_cmd_t op, input logic [15:0] d);
        host_u.xfer(op, d, 0, rd);
    endtask
    task automatic rdchk(input string what, input dbc_pkg::dbc_cmd_t op,
            input logic [15:0] exp);
        host_u.xfer(op, 16'h0000, 1, rd);
        chk(what, exp, rd);
    endtask
    // Let pulses land, then compare totals
    task automatic counts(input int e, input int s);
        repeat (3) @(posedge clk_i);
        chk("entries", e[15:0], n_enter[15:0]);
        chk("interrupts", s[15:0], n_soft_int[15:0]);
    endtask
    task automatic final_report();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard, far beyond the hundred or so cycles used
    initial begin
        #100000;
        failures++;
        final_report();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rdchk("status", dbc_pkg::DBC_CMD_RD_STATUS, 16'h0005);
        rdchk("match", dbc_pkg::DBC_CMD_RD_MATCH, 16'h0000);
        // Status bits in write data must be ignored
        wr(dbc_pkg::DBC_CMD_WR_CONTROL, 16'h004F);
        rdchk("status", dbc_pkg::DBC_CMD_RD_STATUS, 16'h000D);
        chk("clksel", 16'h0001, {15'h0000, clksel});
        wr(dbc_pkg::DBC_CMD_WR_MATCH, 16'hA5C3);
        rdchk("match", dbc_pkg::DBC_CMD_RD_MATCH, 16'hA5C3);
        // Enable bit low: trigger and done give nothing
        cyc(5'b01001);
        cyc(5'b00000);
        counts(0, 0);
        // Force without background enable: interrupt instead
        brk_en <= 1'b1;
        cyc(5'b01000);
        cyc(5'b00000);
        cyc(5'b00001);
        cyc(5'b00000);
        counts(0, 1);
        // Enable background, force with trigger on the done cycle
        wr(dbc_pkg::DBC_CMD_WR_CONTROL, 16'h0080);
        cyc(5'b01001);
        cyc(5'b00000);
        counts(1, 1);
        rdchk("status", dbc_pkg::DBC_CMD_RD_STATUS, 16'h00C5);
        // Active: enable write refused, clock select still taken
        stat <= 3'h2;
        wr(dbc_pkg::DBC_CMD_WR_CONTROL, 16'h0008);
        rdchk("status", dbc_pkg::DBC_CMD_RD_STATUS, 16'h00CA);
        chk("clksel", 16'h0001, {15'h0000, clksel});
        wr(dbc_pkg::DBC_CMD_GO, 16'h0000);
        // Tag: older opcode runs first, marked one halts
        tag_sel <= 1'b1;
        cyc(5'b10000);
        cyc(5'b11000);
        cyc(5'b00100);
        cyc(5'b00000);
        counts(1, 1);
        cyc(5'b00100);
        cyc(5'b00000);
        counts(2, 1);
        wr(dbc_pkg::DBC_CMD_GO, 16'h0000);
        // Marked opcode flushed away never halts
        cyc(5'b11000);
        cyc(5'b00010);
        cyc(5'b10000);
        cyc(5'b00100);
        cyc(5'b00000);
        counts(2, 1);
        // Not active: enable bit clears again
        wr(dbc_pkg::DBC_CMD_WR_CONTROL, 16'h0000);
        rdchk("status", dbc_pkg::DBC_CMD_RD_STATUS, 16'h0002);
        // Host halt: ignored with enable low, taken with it high
        wr(dbc_pkg::DBC_CMD_HALT, 16'h0000);
        counts(2, 1);
        wr(dbc_pkg::DBC_CMD_WR_CONTROL, 16'h0080);
        wr(dbc_pkg::DBC_CMD_HALT, 16'h0000);
        counts(3, 1);
        chk("active", 16'h0001, {15'h0000, act});
        wr(dbc_pkg::DBC_CMD_GO, 16'h0000);
        // Match register breakpoint, tag type: marked fetch halts on exec
        wr(dbc_pkg::DBC_CMD_WR_CONTROL, 16'h00A0);
        fetch.addr <= 16'hA5C3;
        cyc(5'b10000);
        cyc(5'b00100);
        cyc(5'b00000);
        counts(4, 1);
        wr(dbc_pkg::DBC_CMD_GO, 16'h0000);
        // Match register breakpoint, force type: waits for done
        wr(dbc_pkg::DBC_CMD_WR_CONTROL, 16'h00B0);
        cyc(5'b10000);
        cyc(5'b00000);
        cyc(5'b00001);
        cyc(5'b00000);
        counts(5, 1);
        wr(dbc_pkg::DBC_CMD_GO, 16'h0000);
        final_report();
    end
endmodule
